// ==== verilog/sdc_pkg.sv ====
// Package: constants for the squib diagnostic command and status block
`default_nettype none
package sdc_pkg;
    // Command codes
    localparam logic [7:0] CMD_UNLOCK_CNT1 = 8'h80;
    localparam logic [7:0] CMD_UNLOCK_CNT2 = 8'h81;
    localparam logic [7:0] CMD_DIAG_SUPPLY = 8'hC0;
    localparam logic [7:0] CMD_SQUIB_SHORT = 8'hC1;
    localparam logic [7:0] CMD_FIRE_SUPPLY = 8'hC5;
    localparam logic [7:0] CMD_DIAG_THRESH = 8'hC6;
    localparam logic [7:0] CMD_REF_RES = 8'hC8;
    localparam logic [7:0] CMD_RETURN = 8'hC9;
    localparam logic [7:0] CMD_INTEGRITY = 8'h96;
    localparam logic [7:0] RSP_INTEGRITY = 8'h69;
    localparam logic [7:0] RSP_NONE = 8'h00;
    // AHB-Lite register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_LAST_CMD = 8'h0C;
    localparam logic [7:0] REG_CNT1 = 8'h10;
    localparam logic [7:0] REG_CNT2 = 8'h14;
    // Status bit positions
    localparam int ST_BYTE = 0;
    localparam int ST_PROG = 1;
    localparam int ST_DROP = 2;
    localparam int ST_W = 3;
    // Control bit positions
    localparam int CT_FIRING = 0;
    localparam int CT_RET_INH = 1;
    localparam logic [7:0] CNT_RESET = 8'h00;
    // Command tracker states
    typedef enum logic [1:0]
    {
        SDC_IDLE = 2'b00,
        SDC_ARM1 = 2'b01,
        SDC_ARM2 = 2'b10
    } sdc_arm_t;
endpackage : sdc_pkg
`default_nettype wire

// ==== verilog/sdc_core.sv ====
// Squib diagnostic serial command decoder and status encoder
//
// Overview of operation
// - Programming byte ignored while any transistor fires
// - Unlock and programming byte must be consecutive
// - Response byte goes out on next transfer
// - Integrity command 96 answers with 69
// - Resistor ok flags zero when faulty
// - C8 fire enable bits follow pins
// - Safing result only for channels 1A, 2A
// - Safing pair: short 00, open 11, normal 01
// - Closed sensor short, lost connection open
// - C0 diag supply pairs: 11, 01, 00
// - C5 fire supply pairs: 11, 01, 00
// - C6 four threshold bits per diag supply
// - C9 return flag one when open
// - Return test blocked while firing
// - C1 ground short reported below minimum
// - C1 battery short reported above maximum
// - C1 ok bits zero on short, else one
`default_nettype none
module sdc_core
    import sdc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    // Serial link pins
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    // Comparator and pin levels
    input wire logic fire_enable_one,
    input wire logic fire_enable_two,
    input wire logic [1:0] limit_resistor_ok,
    input wire logic diag_resistor_ok,
    input wire logic [1:0] safing_sensor_closed,
    input wire logic [1:0] safing_path_lost,
    input wire logic [1:0] diag_supply_above_high,
    input wire logic [1:0] diag_supply_above_low,
    input wire logic [3:0] fire_supply_above_high,
    input wire logic [3:0] fire_supply_above_low,
    input wire logic [7:0] diag_supply_thresh,
    input wire logic [1:0] fire_return_above,
    input wire logic [3:0] squib_below_min,
    input wire logic [3:0] squib_above_max,
    input wire logic firing_active,
    output logic return_test_enable,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq
);
    // Reset release through two flops
    logic rst_s1_q, rst_n_q;
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Pin inputs pass three flops; change taken when stages two and three agree
    logic [2:0] sclk_q, cs_q, mosi_q;
    logic sclk_f_q, cs_f_q, mosi_f_q;
    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            sclk_q <= 3'h0;
            cs_q <= 3'h7;
            mosi_q <= 3'h0;
            sclk_f_q <= 1'b0;
            cs_f_q <= 1'b1;
            mosi_f_q <= 1'b0;
        end
        else
        begin
            sclk_q <= {sclk_q[1:0], spi_sclk};
            cs_q <= {cs_q[1:0], spi_cs_n};
            mosi_q <= {mosi_q[1:0], spi_mosi};
            if (sclk_q[1] == sclk_q[2]) sclk_f_q <= sclk_q[2];
            if (cs_q[1] == cs_q[2]) cs_f_q <= cs_q[2];
            if (mosi_q[1] == mosi_q[2]) mosi_f_q <= mosi_q[2];
        end
    end

    // Edge detection on the filtered copies (mode 0: sample rise, shift fall)
    logic sclk_p_q, cs_p_q;
    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            sclk_p_q <= 1'b0;
            cs_p_q <= 1'b1;
        end
        else
        begin
            sclk_p_q <= sclk_f_q;
            cs_p_q <= cs_f_q;
        end
    end
    wire sclk_rise = sclk_f_q & ~sclk_p_q & ~cs_f_q;
    wire sclk_fall = ~sclk_f_q & sclk_p_q & ~cs_f_q;
    wire cs_start = ~cs_f_q & cs_p_q;
    wire cs_end = cs_f_q & ~cs_p_q;

    // Receive shift register and bit counter
    logic [7:0] rx_q, tx_q, rsp_q;
    logic [3:0] bits_q;
    wire [7:0] rx_full = rx_q; // Whole byte; decoded only at frame end
    wire byte_done = cs_end & (bits_q == 4'd8);

    // Status encoding helpers
    function automatic logic [1:0] sdc_window(input logic above_hi, input logic above_lo);
        sdc_window = {above_hi & above_lo, above_lo};
    endfunction : sdc_window

    // Safing pair per channel A: short 00, open 11, else 01
    wire [1:0] safe_a1 = safing_sensor_closed[0] ? 2'b00 : (safing_path_lost[0] ? 2'b11 : 2'b01);
    wire [1:0] safe_a2 = safing_sensor_closed[1] ? 2'b00 : (safing_path_lost[1] ? 2'b11 : 2'b01);
    // C0: safing for 1A and 2A only, then diag supply pairs
    wire [7:0] rsp_c0 = {safe_a2, safe_a1,
        sdc_window(diag_supply_above_high[1], diag_supply_above_low[1]),
        sdc_window(diag_supply_above_high[0], diag_supply_above_low[0])};
    wire [7:0] rsp_c5 = {sdc_window(fire_supply_above_high[3], fire_supply_above_low[3]),
        sdc_window(fire_supply_above_high[2], fire_supply_above_low[2]),
        sdc_window(fire_supply_above_high[1], fire_supply_above_low[1]),
        sdc_window(fire_supply_above_high[0], fire_supply_above_low[0])};
    wire [7:0] rsp_c6 = diag_supply_thresh;
    // C8: enables, resistor flags (one when healthy)
    wire [7:0] rsp_c8 = {3'h0, fire_enable_two, fire_enable_one, diag_resistor_ok, limit_resistor_ok};
    // Return flags held at last result while firing, test blocked
    logic [1:0] ret_q;
    wire [7:0] rsp_c9 = {6'h00, ret_q};
    // C1: per squib no_battery_short / no_ground_short
    logic [7:0] rsp_c1;
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            rsp_c1[2*i+1] = ~squib_above_max[i];
            rsp_c1[2*i] = ~squib_below_min[i];
        end
    end

    // Command tracker
    sdc_arm_t arm_q;
    logic [7:0] cnt1_q, cnt2_q, last_q;
    logic [ST_W-1:0] st_q, mask_q;
    logic [1:0] ctrl_q;
    wire firing = firing_active | ctrl_q[CT_FIRING];
    wire is_unlock = (rx_full == CMD_UNLOCK_CNT1) | (rx_full == CMD_UNLOCK_CNT2);
    wire armed = (arm_q != SDC_IDLE);
    wire prog_ok = armed & ~firing;
    wire prog_drop = armed & firing;
    assign return_test_enable = ~firing & ~ctrl_q[CT_RET_INH];

    // Response selection for the byte just received
    logic [7:0] rsp_d;
    always_comb
    begin
        rsp_d = RSP_NONE;
        if (armed)
            rsp_d = prog_ok ? rx_full : RSP_NONE;
        else
        begin
            case (rx_full)
                CMD_INTEGRITY: rsp_d = RSP_INTEGRITY;
                CMD_UNLOCK_CNT1, CMD_UNLOCK_CNT2: rsp_d = rx_full;
                CMD_DIAG_SUPPLY: rsp_d = rsp_c0;
                CMD_SQUIB_SHORT: rsp_d = rsp_c1;
                CMD_FIRE_SUPPLY: rsp_d = rsp_c5;
                CMD_DIAG_THRESH: rsp_d = rsp_c6;
                CMD_REF_RES: rsp_d = rsp_c8;
                CMD_RETURN: rsp_d = rsp_c9;
                default: rsp_d = RSP_NONE;
            endcase
        end
    end

    // Serial shifting; response latched at byte end, sent next frame
    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            rsp_q <= 8'h00;
            bits_q <= 4'h0;
        end
        else
        begin
            if (cs_start)
            begin
                bits_q <= 4'h0;
                tx_q <= rsp_q;
            end
            else if (sclk_rise)
            begin
                rx_q <= {rx_q[6:0], mosi_f_q};
                // Saturates past eight so a long frame is refused as well
                if (bits_q != 4'd9) bits_q <= bits_q + 4'd1;
            end
            else if (sclk_fall) tx_q <= {tx_q[6:0], 1'b0};
            if (byte_done) rsp_q <= rsp_d;
        end
    end
    assign spi_miso = tx_q[7];
    assign spi_miso_oe = ~cs_f_q;

    // Response path checks; rsp_q is what the next frame carries
    sequence s_took(logic [7:0] cmd);
        byte_done && !armed && rx_full == cmd;
    endsequence
    property p_next;
        @(posedge clk_sys) disable iff (!rst_n_q) cs_start |=> tx_q == $past(rsp_q);
    endproperty
    a_next: assert property (p_next) else $error("response not loaded");
    property p_integrity;
        @(posedge clk_sys) disable iff (!rst_n_q) s_took(CMD_INTEGRITY) |=> rsp_q == RSP_INTEGRITY;
    endproperty
    a_integrity: assert property (p_integrity) else $error("integrity answer wrong");
    property p_c8;
        @(posedge clk_sys) disable iff (!rst_n_q)
        s_took(CMD_REF_RES) |=> rsp_q[4] == $past(fire_enable_two) && rsp_q[3] == $past(fire_enable_one);
    endproperty
    a_c8: assert property (p_c8) else $error("enable bits");
    property p_safe;
        @(posedge clk_sys) disable iff (!rst_n_q)
        s_took(CMD_DIAG_SUPPLY) |=> !$past(safing_sensor_closed[0]) || rsp_q[5:4] == 2'b00;
    endproperty
    a_safe: assert property (p_safe) else $error("safing short");
    property p_c1;
        @(posedge clk_sys) disable iff (!rst_n_q)
        s_took(CMD_SQUIB_SHORT) |=> rsp_q[1] == !$past(squib_above_max[0]);
    endproperty
    a_c1: assert property (p_c1) else $error("battery short");

    // Unlock/program sequencing: any intervening byte disarms
    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            arm_q <= SDC_IDLE;
            cnt1_q <= CNT_RESET;
            cnt2_q <= CNT_RESET;
            last_q <= 8'h00;
        end
        else if (byte_done)
        begin
            last_q <= rx_full;
            if (armed)
            begin
                arm_q <= SDC_IDLE;
                if (prog_ok && arm_q == SDC_ARM1) cnt1_q <= rx_full;
                if (prog_ok && arm_q == SDC_ARM2) cnt2_q <= rx_full;
            end
            else if (is_unlock)
                arm_q <= (rx_full == CMD_UNLOCK_CNT1) ? SDC_ARM1 : SDC_ARM2;
        end
    end

    // Sequencing guards: a dropped byte leaves both counters alone
    property p_nofire;
        @(posedge clk_sys) disable iff (!rst_n_q)
        (byte_done && prog_drop) |=> cnt1_q == $past(cnt1_q) && cnt2_q == $past(cnt2_q);
    endproperty
    a_nofire: assert property (p_nofire) else $error("program while firing");
    property p_disarm;
        @(posedge clk_sys) disable iff (!rst_n_q) (byte_done && armed) |=> arm_q == SDC_IDLE;
    endproperty
    a_disarm: assert property (p_disarm) else $error("not disarmed");

    // Return test result only updates while the test runs
    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q) ret_q <= 2'b00;
        else if (return_test_enable) ret_q <= fire_return_above;
    end

    // Result frozen while firing blocks the return test
    property p_ret;
        @(posedge clk_sys) disable iff (!rst_n_q) firing |=> ret_q == $past(ret_q);
    endproperty
    a_ret: assert property (p_ret) else $error("return test while firing");

    // Bus slave: register the address phase
    logic wr_q, rd_q;
    logic [7:0] addr_q;
    wire take = hsel & hready & htrans[1];
    wire [ST_W-1:0] ev = {prog_drop & byte_done, prog_ok & byte_done, byte_done};
    wire [ST_W-1:0] w1c = (wr_q && addr_q == REG_STATUS) ? hwdata[ST_W-1:0] : '0;
    always_ff @(posedge clk_sys or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 8'h00;
            st_q <= '0;
            mask_q <= '0;
            ctrl_q <= 2'b00;
        end
        else
        begin
            wr_q <= take & hwrite;
            rd_q <= take & ~hwrite;
            addr_q <= haddr[7:0];
            // Set wins over a same-cycle clear
            st_q <= (st_q & ~w1c) | ev;
            if (wr_q && addr_q == REG_MASK) mask_q <= hwdata[ST_W-1:0];
            if (wr_q && addr_q == REG_CTRL) ctrl_q <= hwdata[1:0];
        end
    end

    // Read mux; unmapped offsets read zero
    logic [31:0] rdata_d;
    always_comb
    begin
        case (addr_q)
            REG_STATUS: rdata_d = {29'h0, st_q};
            REG_MASK: rdata_d = {29'h0, mask_q};
            REG_CTRL: rdata_d = {30'h0, ctrl_q};
            REG_LAST_CMD: rdata_d = {24'h0, last_q};
            REG_CNT1: rdata_d = {24'h0, cnt1_q};
            REG_CNT2: rdata_d = {24'h0, cnt2_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end
    assign hrdata = rd_q ? rdata_d : 32'h0000_0000;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = |(st_q & mask_q);
endmodule : sdc_core
`default_nettype wire

// ==== verif/sdc_spi_host.sv ====
// SPI host model sending one-byte diagnostic frames
`default_nettype none
module sdc_spi_host
(
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    timeunit 1ns;
    timeprecision 100ps;
    // Link idles deselected, clock parked low
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // Whole byte per frame, MSB first; reply belongs to the previous frame
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        // Pins move after the block's clock edge, never racing it
        spi_cs_n <= 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            spi_mosi <= tx[i];
            #80 spi_sclk <= 1'b1;
            rx[i] = spi_miso;
            #80 spi_sclk <= 1'b0;
        end
        #80 spi_cs_n <= 1'b1;
        // Released data line flips so a stale bit is never trusted
        spi_mosi <= ~spi_mosi;
        #240;
    endtask : xfer
endmodule : sdc_spi_host
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the squib diagnostic command block
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED %0t mismatch %h %h", $time, (a), (b)); end end
module tb
    import sdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, rstn, fire_enable_one, fire_enable_two, diag_resistor_ok, firing_active, hsel, hwrite;
    logic [1:0] limit_resistor_ok, safing_sensor_closed, safing_path_lost, htrans;
    logic [1:0] diag_supply_above_high, diag_supply_above_low, fire_return_above;
    logic [3:0] fire_supply_above_high, fire_supply_above_low, squib_below_min, squib_above_max;
    logic [7:0] diag_supply_thresh, rx;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, rd, seed, r2;
    logic [15:0] pend;
    wire logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, return_test_enable, hreadyout, hresp, irq;
    wire logic [31:0] hrdata;
    int num_errors, comparisons, cycles;
    // Never the reserved codes 90 to 93
    logic [7:0] cmds [8] = '{8'hC0, 8'hC1, 8'hC5, 8'hC6, 8'hC8, 8'hC9, 8'h96, 8'h5A};

    sdc_core i_dut (.clk_sys, .rstn, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe,
        .fire_enable_one, .fire_enable_two, .limit_resistor_ok, .diag_resistor_ok, .safing_sensor_closed,
        .safing_path_lost, .diag_supply_above_high, .diag_supply_above_low, .fire_supply_above_high,
        .fire_supply_above_low, .diag_supply_thresh, .fire_return_above, .squib_below_min, .squib_above_max,
        .firing_active, .return_test_enable, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
        .hwdata, .hrdata, .hreadyout, .hresp, .irq);
    sdc_spi_host i_host (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    function automatic logic [1:0] pr(input logic h, input logic l);
        return h ? 2'b11 : {1'b0, l};
    endfunction : pr
    function automatic logic [1:0] sf(input logic c, input logic o);
        return c ? 2'b00 : (o ? 2'b11 : 2'b01);
    endfunction : sf
    // Mask in the upper byte, expected reply in the lower
    function automatic logic [15:0] expect_rsp(input logic [7:0] c);
        logic [7:0] v;
        for (int i = 0; i < 4; i++)
        begin
            v[2*i+1] = (c == 8'hC1) ? ~squib_above_max[i] : fire_supply_above_high[i];
            v[2*i] = (c == 8'hC1) ? ~squib_below_min[i] : fire_supply_above_low[i] | v[2*i+1];
        end
        case (c)
            8'hC0: return {8'hFF, sf(safing_sensor_closed[1], safing_path_lost[1]),
                sf(safing_sensor_closed[0], safing_path_lost[0]), pr(diag_supply_above_high[1],
                diag_supply_above_low[1]), pr(diag_supply_above_high[0], diag_supply_above_low[0])};
            8'hC1, 8'hC5: return {8'hFF, v};
            8'hC6: return {8'hFF, diag_supply_thresh};
            8'hC8: return {11'h0F8, fire_enable_two, fire_enable_one, diag_resistor_ok, limit_resistor_ok};
            8'hC9: return {8'hFF, 6'h00, fire_return_above};
            8'h96: return 16'hFF69;
            default: return 16'hFF00;
        endcase
    endfunction : expect_rsp
    // Single word transfer; waits on the answer rather than assuming zero wait
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        hsel <= 1'b1;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask : ahb
    task automatic results();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    task automatic frame(input logic [7:0] c, input logic [7:0] e);
        i_host.xfer(c, rx);
        `CHK(rx, e)
    endtask : frame

    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            num_errors++;
            results();
        end
    end
    // Main sequence
    initial
    begin
        {rstn, fire_enable_one, fire_enable_two, diag_resistor_ok, firing_active, hsel, hwrite} = '0;
        {limit_resistor_ok, safing_sensor_closed, safing_path_lost, htrans, fire_return_above} = '0;
        {diag_supply_above_high, diag_supply_above_low, fire_supply_above_high, fire_supply_above_low} = '0;
        {squib_below_min, squib_above_max, diag_supply_thresh, haddr, hwdata} = '0;
        hsize = 3'b010;
        seed = 32'h90c2;
        pend = 16'hFF00;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        for (int n = 0; n < 48; n++)
        begin
            @(posedge clk_sys);
            seed = xs(seed);
            r2 = xs(seed);
            {fire_enable_two, fire_enable_one, limit_resistor_ok, diag_resistor_ok} <= seed[4:0];
            safing_sensor_closed <= seed[6:5];
            safing_path_lost <= seed[8:7] & ~seed[6:5];
            diag_supply_above_high <= seed[10:9];
            diag_supply_above_low <= seed[12:11] | seed[10:9];
            fire_supply_above_high <= seed[16:13];
            fire_supply_above_low <= seed[20:17] | seed[16:13];
            fire_return_above <= seed[22:21];
            diag_supply_thresh <= r2[7:0];
            squib_below_min <= r2[11:8];
            squib_above_max <= r2[15:12] & ~r2[11:8];
            i_host.xfer(cmds[n % 8], rx);
            `CHK(rx & pend[15:8], pend[7:0])
            pend = expect_rsp(cmds[n % 8]);
            `CHK(return_test_enable, 1'b1)
        end
        i_host.xfer(8'h80, rx);
        `CHK(rx & pend[15:8], pend[7:0])
        frame(8'hA5, 8'h80);
        frame(8'h96, 8'hA5);
        ahb(1'b0, REG_CNT1, 32'h0);
        `CHK(rd[7:0], 8'hA5)
        // Program byte follows its unlock at once; the byte after is a plain command
        frame(8'h81, 8'h69);
        frame(8'h3C, 8'h81);
        frame(8'h5A, 8'h3C);
        frame(8'h96, 8'h00);
        ahb(1'b0, REG_CNT2, 32'h0);
        `CHK(rd[7:0], 8'h3C)
        @(posedge clk_sys);
        firing_active <= 1'b1;
        #20 `CHK(return_test_enable, 1'b0)
        frame(8'h81, 8'h69);
        frame(8'h77, 8'h81);
        frame(8'h96, 8'h00);
        ahb(1'b0, REG_CNT2, 32'h0);
        `CHK(rd[7:0], 8'h3C)
        firing_active <= 1'b0;
        ahb(1'b1, REG_CTRL, 32'h2);
        #20 `CHK(return_test_enable, 1'b0)
        ahb(1'b1, REG_CTRL, 32'h0);
        ahb(1'b1, REG_MASK, 32'h1);
        ahb(1'b0, REG_STATUS, 32'h0);
        `CHK(rd[0], 1'b1)
        #20 `CHK(irq, 1'b1)
        ahb(1'b1, REG_STATUS, 32'h1);
        #20 `CHK(irq, 1'b0)
        ahb(1'b0, 8'h20, 32'h0);
        `CHK({hresp, rd}, 33'h0)
        results();
    end
endmodule : tb
`default_nettype wire
